// ### cwsl_loader.sv
// Configuration word shadow loader: copies the configuration words from flash into read-only
// shadow registers after every reset and serves them over an Avalon-MM slave.
// Assumes a flash read port on sys_clk that holds data valid for one cycle per request, and a
// reset input that is asserted by every device reset source, this block's own request included.
//
// Summary of operation
// - Shadows are volatile, reloaded after every power-up.
// - Reset copies the eight configuration words of the loaded panel into their shadows.
// - Full reload on every kind of reset.
// - Dual mode: boot sequence picks the loaded panel.
// - Words sit at size-dependent base, 16 bytes from the first to the second, then four apart.
// - Fetch from configuration space forces a reset.
// - Last-page erase also erases configuration words.
// - Soft swap keeps shadows until next reset.
`timescale 1ns/10ps
`include "cwsl_params.svh"
module cwsl_loader
    import cwsl_pkg::*;
(
    input  wire logic            sys_clk,            // System clock, 20 MHz.
    input  wire logic            reset,              // Any device reset, active high.
    input  wire cwsl_size_e      mem_size,           // Program memory size strap.
    input  wire logic            dual_partition,     // Dual partition mode strap.
    output cwsl_flash_req_s      flash_req,          // Flash read request and address.
    input  wire cwsl_flash_rsp_s flash_rsp,          // Flash read data and valid.
    input  wire logic            erase_strobe,       // Flash page erase performed.
    input  wire logic [23:0]     erase_addr,         // Address inside the erased page.
    input  wire logic            soft_swap,          // Partition soft swap pulse.
    input  wire logic            fetch_valid,        // Core instruction fetch.
    input  wire logic [23:0]     fetch_addr,         // Core fetch address.
    output logic                 cfg_space_reset,    // Reset request from a bad fetch.
    output logic                 cfg_loaded,         // Shadows hold the loaded words.
    output logic                 active_panel,       // Active partition, 0 or 1.
    input  wire logic [15:0]     avs_address,        // Avalon byte address.
    input  wire logic            avs_read,           // Avalon read.
    input  wire logic            avs_write,          // Avalon write, ignored.
    input  wire logic [31:0]     avs_writedata,      // Avalon write data, ignored.
    output logic [31:0]          avs_readdata,       // Avalon read data.
    output logic                 avs_waitrequest     // Avalon wait request.
);
    cwsl_state_e  state_q;
    cwsl_size_e   size_q;
    logic         dual_q;
    logic [2:0]   idx_q;
    logic [23:0]  seq1_q;
    logic         panel_q;
    logic         loaded_q;
    logic         erased_q;
    logic         execrst_seen_q;
    logic         req_q;
    logic [23:0]  addr_q;
    logic         ack_q;
    logic [31:0]  rdata_q;
    logic [23:0]  shadow_q [`CWSL_NUM_WORDS];
    logic [23:0]  seq_word_q;
    logic [23:0]  base;
    logic [23:0]  panel_ofs;
    logic         pick_two;
    logic         exec_rst;

    // Word offsets from the base; the gap after the first word is fixed by the flash layout.
    function automatic logic [23:0] word_ofs(input logic [2:0] idx);
        word_ofs = (idx == 3'h0) ? 24'h000000 : 24'h00000C + {19'h0, idx, 2'h0};
    endfunction

    function automatic logic seq_ok(input logic [23:0] w);
        seq_ok = (w[23:`CWSL_SEQ_INV_LSB] == ~w[`CWSL_SEQ_MSB:0]);
    endfunction

    // Lower valid sequence number wins; a tie or two invalid words keep the first panel.
    function automatic logic choose_two(input logic [23:0] w1, input logic [23:0] w2);
        if (seq_ok(w1) && seq_ok(w2))
            choose_two = (w2[`CWSL_SEQ_MSB:0] < w1[`CWSL_SEQ_MSB:0]);
        else
            choose_two = seq_ok(w2) && !seq_ok(w1);
    endfunction

    assign base      = cwsl_base(size_q);
    assign panel_ofs = panel_q ? `CWSL_PANEL2_OFS : 24'h000000;
    assign pick_two  = choose_two(seq1_q, flash_rsp.data);

    // The loader starts again from the top after every reset release.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_START;
            size_q  <= CWSL_MEM_16K;
            dual_q  <= 1'b0;
            idx_q   <= 3'h0;
            seq1_q  <= `CWSL_ERASED;
            req_q   <= 1'b0;
            addr_q  <= 24'h000000;
        end
        else
        begin
            unique case (state_q)
                ST_START:
                begin
                    size_q <= mem_size;
                    dual_q <= dual_partition;
                    req_q  <= 1'b1;
                    if (dual_partition)
                    begin
                        state_q <= ST_SEQ1;
                        addr_q  <= cwsl_base(mem_size) + `CWSL_OFS_BOOT;
                    end
                    else
                    begin
                        state_q <= ST_WORDS;
                        addr_q  <= cwsl_base(mem_size);
                    end
                end
                ST_SEQ1:
                    if (flash_rsp.valid)
                    begin
                        seq1_q  <= flash_rsp.data;
                        addr_q  <= base + `CWSL_OFS_BOOT + `CWSL_PANEL2_OFS;
                        state_q <= ST_SEQ2;
                    end
                ST_SEQ2:
                    if (flash_rsp.valid)
                    begin
                        addr_q  <= base + (pick_two ? `CWSL_PANEL2_OFS : 24'h000000);
                        state_q <= ST_WORDS;
                    end
                ST_WORDS:
                    if (flash_rsp.valid)
                    begin
                        if (idx_q == 3'(`CWSL_NUM_WORDS - 1))
                        begin
                            req_q   <= 1'b0;
                            state_q <= ST_DONE;
                        end
                        else
                        begin
                            idx_q  <= idx_q + 3'h1;
                            addr_q <= base + panel_ofs + word_ofs(idx_q + 3'h1);
                        end
                    end
                ST_DONE:
                    req_q <= 1'b0;
            endcase
        end
    end

    // Panel choice is made at load time; a soft swap only flips the reported panel.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            panel_q <= 1'b0;
        else if (state_q == ST_SEQ2 && flash_rsp.valid)
            panel_q <= pick_two;
        else if (state_q == ST_DONE && dual_q && soft_swap)
            panel_q <= ~panel_q;
    end

    // Shadows start erased after any reset, so nothing survives a power loss.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < `CWSL_NUM_WORDS; i++)
                shadow_q[i] <= `CWSL_ERASED;
        end
        else if (state_q == ST_WORDS && flash_rsp.valid)
            shadow_q[idx_q] <= flash_rsp.data;
    end

    // Boot sequence word of the panel that was loaded.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            seq_word_q <= `CWSL_ERASED;
        else if (state_q == ST_SEQ2 && flash_rsp.valid)
            seq_word_q <= pick_two ? flash_rsp.data : seq1_q;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            loaded_q <= 1'b0;
        else if (state_q == ST_WORDS && flash_rsp.valid && idx_q == 3'(`CWSL_NUM_WORDS - 1))
            loaded_q <= 1'b1;
    end

    // Erasing the last page wipes the words in flash; the next reset loads them erased.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            erased_q <= 1'b0;
        else if (erase_strobe && ((erase_addr & `CWSL_PAGE_MASK) == (base & `CWSL_PAGE_MASK)))
            erased_q <= 1'b1;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            execrst_seen_q <= 1'b0;
        else if (exec_rst)
            execrst_seen_q <= 1'b1;
    end

    cwsl_fetch_guard u_fetch_guard
    (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .mem_size    (size_q),
        .fetch_valid (fetch_valid),
        .fetch_addr  (fetch_addr),
        .exec_rst_q  (exec_rst)
    );

    // Avalon slave: one wait cycle, then the registered answer; writes are accepted and dropped.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            ack_q <= 1'b0;
        else
            ack_q <= (avs_read || avs_write) && !ack_q;
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            rdata_q <= 32'h00000000;
        else if (avs_read && !ack_q)
        begin
            unique case (avs_address)
                `CWSL_REG_SEC:    rdata_q <= {8'h00, shadow_q[0]};
                `CWSL_REG_BSLIM:  rdata_q <= {8'h00, shadow_q[1]};
                `CWSL_REG_SIGN:   rdata_q <= {8'h00, shadow_q[2]};
                `CWSL_REG_OSCSEL: rdata_q <= {8'h00, shadow_q[3]};
                `CWSL_REG_OSC:    rdata_q <= {8'h00, shadow_q[4]};
                `CWSL_REG_WDT:    rdata_q <= {8'h00, shadow_q[5]};
                `CWSL_REG_POR:    rdata_q <= {8'h00, shadow_q[6]};
                `CWSL_REG_DBG:    rdata_q <= {8'h00, shadow_q[7]};
                `CWSL_REG_BOOT:   rdata_q <= {8'h00, seq_word_q};
                `CWSL_REG_STATUS: rdata_q <= {27'h0, execrst_seen_q, erased_q, dual_q,
                                               panel_q, loaded_q};
                default:          rdata_q <= 32'h00000000;
            endcase
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign avs_readdata    = rdata_q;
    assign flash_req.req   = req_q;
    assign flash_req.addr  = addr_q;
    assign cfg_loaded      = loaded_q;
    assign active_panel    = panel_q;
    assign cfg_space_reset = exec_rst;

    a_erased_at_reset: assert property (@(posedge sys_clk)
        $fell(reset) |-> (shadow_q[0] == `CWSL_ERASED && !loaded_q))
        else $error("Shadow not erased after reset.");

    a_word_stored: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_WORDS && flash_rsp.valid)
        |=> shadow_q[$past(idx_q)] == $past(flash_rsp.data))
        else $error("Flash word not copied into shadow.");

    a_restart_load: assert property (@(posedge sys_clk)
        $fell(reset) |-> (state_q == ST_START && idx_q == 3'h0))
        else $error("Load does not restart after reset.");

    a_panel_pick: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_WORDS && dual_q && idx_q == 3'h0 && req_q)
        |-> addr_q == base + (panel_q ? `CWSL_PANEL2_OFS : 24'h000000))
        else $error("Words fetched from the wrong panel.");

    a_word_address: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_WORDS && !dual_q) |-> addr_q == base + word_ofs(idx_q))
        else $error("Configuration word address wrong.");

    a_erase_flag: assert property (@(posedge sys_clk) disable iff (reset)
        (erase_strobe && ((erase_addr & `CWSL_PAGE_MASK) == (base & `CWSL_PAGE_MASK)))
        |=> erased_q)
        else $error("Last page erase not flagged.");

    a_swap_keeps: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == ST_DONE && dual_q && soft_swap) |=> (panel_q != $past(panel_q))
        && shadow_q[0] == $past(shadow_q[0]) && !req_q)
        else $error("Soft swap disturbed the shadows.");

    a_write_ignored: assert property (@(posedge sys_clk) disable iff (reset)
        (avs_write && state_q == ST_DONE) |=> $stable(shadow_q[7]) && $stable(shadow_q[0]))
        else $error("Software write changed a shadow.");

    a_bus_answer: assert property (@(posedge sys_clk) disable iff (reset)
        (avs_read && avs_waitrequest) |=> (avs_read |-> !avs_waitrequest))
        else $error("Read not answered in one wait cycle.");

    c_single_load: cover property (@(posedge sys_clk) disable iff (reset)
        !dual_q && $rose(loaded_q));
    c_second_panel: cover property (@(posedge sys_clk) disable iff (reset)
        dual_q && panel_q && $rose(loaded_q));
    c_swap: cover property (@(posedge sys_clk) disable iff (reset)
        state_q == ST_DONE && dual_q && soft_swap);
    c_exec_reset: cover property (@(posedge sys_clk) disable iff (reset) exec_rst);
endmodule

// ### cwsl_params.svh
// Constants of the configuration word shadow loader: flash offsets, register offsets and
// reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CWSL_PARAMS_SVH
`define CWSL_PARAMS_SVH
`define CWSL_BASE_16K    24'h002B80
`define CWSL_BASE_32K    24'h005780
`define CWSL_BASE_64K    24'h00AF80
`define CWSL_CFG_SPAN    24'h000080
`define CWSL_PANEL2_OFS  24'h400000
`define CWSL_PAGE_MASK   24'hFFF800
`define CWSL_OFS_BOOT    24'h00007C
`define CWSL_ERASED      24'hFFFFFF
`define CWSL_NUM_WORDS   8
`define CWSL_SEQ_MSB     11
`define CWSL_SEQ_INV_LSB 12
`define CWSL_REG_SEC     16'h2B80
`define CWSL_REG_BSLIM   16'h2B90
`define CWSL_REG_SIGN    16'h2B94
`define CWSL_REG_OSCSEL  16'h2B98
`define CWSL_REG_OSC     16'h2B9C
`define CWSL_REG_WDT     16'h2BA0
`define CWSL_REG_POR     16'h2BA4
`define CWSL_REG_DBG     16'h2BA8
`define CWSL_REG_BOOT    16'h2BFC
`define CWSL_REG_STATUS  16'h2C00
`define CWSL_ST_DONE     0
`define CWSL_ST_PANEL    1
`define CWSL_ST_DUAL     2
`define CWSL_ST_ERASED   3
`define CWSL_ST_EXECRST  4
`endif

// ### cwsl_pkg.sv
// Types and shared decoding of the configuration word shadow loader.
// Assumes cwsl_params.svh is on the include path.
`include "cwsl_params.svh"
package cwsl_pkg;
    typedef enum logic [1:0] {CWSL_MEM_16K, CWSL_MEM_32K, CWSL_MEM_64K, CWSL_MEM_RSVD} cwsl_size_e;
    typedef enum {ST_START, ST_SEQ1, ST_SEQ2, ST_WORDS, ST_DONE} cwsl_state_e;
    typedef struct packed
    {
        logic        req;
        logic [23:0] addr;
    } cwsl_flash_req_s;
    typedef struct packed
    {
        logic        valid;
        logic [23:0] data;
    } cwsl_flash_rsp_s;

    // Base of the configuration words for each memory size; unused code falls to 16 Kbyte.
    function automatic logic [23:0] cwsl_base(input cwsl_size_e size);
        case (size)
            CWSL_MEM_32K: cwsl_base = `CWSL_BASE_32K;
            CWSL_MEM_64K: cwsl_base = `CWSL_BASE_64K;
            default:      cwsl_base = `CWSL_BASE_16K;
        endcase
    endfunction
endpackage

// ### cwsl_fetch_guard.sv
// Watches instruction fetches and asks for a device reset on a fetch from configuration space.
// Assumes fetch signals come from core logic on sys_clk.
`timescale 1ns/10ps
`include "cwsl_params.svh"
module cwsl_fetch_guard
    import cwsl_pkg::*;
(
    input  wire logic        sys_clk,     // System clock.
    input  wire logic        reset,       // Asynchronous reset, active high.
    input  wire cwsl_size_e  mem_size,    // Captured memory size.
    input  wire logic        fetch_valid, // Core is fetching an instruction.
    input  wire logic [23:0] fetch_addr,  // Program address of the fetch.
    output logic             exec_rst_q   // One-cycle reset request.
);
    logic [23:0] base;
    logic        hit;

    assign base = cwsl_base(mem_size);
    assign hit  = fetch_valid && (fetch_addr >= base) && (fetch_addr < base + `CWSL_CFG_SPAN);

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            exec_rst_q <= 1'b0;
        else
            exec_rst_q <= hit;
    end

    a_exec_reset_follows: assert property (@(posedge sys_clk) disable iff (reset)
        hit |=> exec_rst_q)
        else $error("Fetch from configuration space raised no reset.");
endmodule

// ### cwsl_flash_model.sv
// Behavioural program flash that answers the loader's word reads.
// Assumes the bench fills mem directly and pulses erase_strobe as the device would.
`timescale 1ns/10ps
`include "cwsl_params.svh"
module cwsl_flash_model
    import cwsl_pkg::*;
(
    input  wire logic            sys_clk,      // System clock.
    input  wire logic            reset,        // Device reset, active high.
    input  wire cwsl_flash_req_s flash_req,    // Read request from the loader.
    input  wire logic [1:0]      lat,          // Wait cycles before each answer.
    input  wire logic            erase_strobe, // Page erase pulse.
    input  wire logic [23:0]     erase_addr,   // Address inside the erased page.
    output cwsl_flash_rsp_s      flash_rsp     // Read data and valid pulse.
);
    logic [23:0] mem [int];
    int          wait_cnt;

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            flash_rsp <= '0;
            wait_cnt  <= 0;
        end
        else if (flash_req.req && !flash_rsp.valid && wait_cnt >= lat)
        begin
            flash_rsp.valid <= 1'b1;
            flash_rsp.data  <= mem.exists(flash_req.addr) ? mem[flash_req.addr] : `CWSL_ERASED;
            wait_cnt        <= 0;
        end
        else
        begin
            // Data is not held past the pulse, so a loader that samples late reads garbage.
            flash_rsp.valid <= 1'b0;
            flash_rsp.data  <= ~flash_rsp.data;
            wait_cnt        <= flash_req.req ? wait_cnt + 1 : 0;
        end
    end

    always @(posedge sys_clk)
    begin
        int gone [$];
        if (erase_strobe)
        begin
            gone.delete();
            foreach (mem[a])
                if ((a & `CWSL_PAGE_MASK) == (erase_addr & `CWSL_PAGE_MASK))
                    gone.push_back(a);
            foreach (gone[i])
                mem.delete(gone[i]);
        end
    end
endmodule

// ### cwsl_loader_tb_top.sv
// Self-checking bench of the shadow loader with a behavioural flash at its far side.
// Assumes the loader package, header and flash model are compiled first.
`timescale 1ns/10ps
`include "cwsl_params.svh"
module cwsl_loader_tb_top
    import cwsl_pkg::*;
;
    logic            sys_clk;
    logic            reset          = 1'b1;
    cwsl_size_e      mem_size       = CWSL_MEM_16K;
    logic            dual_partition = 1'b0;
    logic            erase_strobe   = 1'b0;
    logic [23:0]     erase_addr     = 24'h000000;
    logic            soft_swap      = 1'b0;
    logic            fetch_valid    = 1'b0;
    logic [23:0]     fetch_addr     = 24'h000000;
    logic [15:0]     avs_address    = 16'h0000;
    logic            avs_read       = 1'b0;
    logic            avs_write      = 1'b0;
    logic [31:0]     avs_writedata  = 32'h00000000;
    logic [1:0]      lat            = 2'h3;
    logic [31:0]     seed           = 32'hCE45;
    int              bad_count      = 0;
    int              n_compared     = 0;
    cwsl_flash_req_s flash_req;
    cwsl_flash_rsp_s flash_rsp;
    logic            cfg_space_reset;
    logic            cfg_loaded;
    logic            active_panel;
    logic [31:0]     avs_readdata;
    logic            avs_waitrequest;
    logic [31:0]     rd;
    logic [23:0]     word_ofs [8] = '{24'h000000, 24'h000010, 24'h000014, 24'h000018,
                                      24'h00001C, 24'h000020, 24'h000024, 24'h000028};
    logic [15:0]     reg_adr [8]  = '{`CWSL_REG_SEC, `CWSL_REG_BSLIM, `CWSL_REG_SIGN,
                                      `CWSL_REG_OSCSEL, `CWSL_REG_OSC, `CWSL_REG_WDT,
                                      `CWSL_REG_POR, `CWSL_REG_DBG};
    logic [23:0]     seq1 [5]     = '{24'hFFA005, 24'hFFD002, 24'h000000, 24'h000000, 24'hFFB004};
    logic [23:0]     seq2 [5]     = '{24'hFFC003, 24'hFF8007, 24'hFFE001, 24'h000000, 24'hFFB004};

    cwsl_loader i_cwsl_loader (.sys_clk(sys_clk), .reset(reset), .mem_size(mem_size),
        .dual_partition(dual_partition), .flash_req(flash_req), .flash_rsp(flash_rsp),
        .erase_strobe(erase_strobe), .erase_addr(erase_addr), .soft_swap(soft_swap),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .cfg_space_reset(cfg_space_reset),
        .cfg_loaded(cfg_loaded), .active_panel(active_panel), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    cwsl_flash_model i_cwsl_flash_model (.sys_clk(sys_clk), .reset(reset), .flash_req(flash_req),
        .lat(lat), .erase_strobe(erase_strobe), .erase_addr(erase_addr), .flash_rsp(flash_rsp));

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [23:0] wword(input logic [23:0] a);
        wword = i_cwsl_flash_model.mem.exists(a) ? i_cwsl_flash_model.mem[a] : `CWSL_ERASED;
    endfunction

    function automatic logic pick(input logic [23:0] w1, input logic [23:0] w2);
        logic v1, v2;
        v1 = (w1[23:12] == ~w1[11:0]);
        v2 = (w2[23:12] == ~w2[11:0]);
        pick = (v1 && v2) ? (w2[11:0] < w1[11:0]) : v2;
    endfunction

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [15:0] a, output logic [31:0] d);
        int n;
        n = 0;
        seed = lfsr(seed);
        avs_address   <= a;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= seed;
        // The request is held until an edge that samples waitrequest low; data is taken there.
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 20)
        begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 20)
            bad_count++;
        d = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic fill(input logic [23:0] base);
        logic [23:0] v;
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 8; i++)
            begin
                seed = lfsr(seed);
                v = seed[23:0];
                if (i == 6) v[0] = 1'b1;
                if (i == 7) v[7] = 1'b1;
                i_cwsl_flash_model.mem[base + (p ? 24'h400000 : 24'h0) + word_ofs[i]] = v;
            end
    endtask

    task automatic pulse_in(input logic [23:0] a, input logic swap, input logic exp);
        fetch_valid <= !swap;
        fetch_addr  <= a;
        soft_swap   <= swap;
        @(posedge sys_clk);
        fetch_valid <= 1'b0;
        soft_swap   <= 1'b0;
        #1;
        check({31'h0, swap ? active_panel : cfg_space_reset}, {31'h0, exp});
        @(posedge sys_clk);
    endtask

    task automatic load_check(input cwsl_size_e size, input logic dual, input logic erased);
        logic [23:0] base, pofs, e;
        logic        p;
        int          n;
        mem_size       <= size;
        dual_partition <= dual;
        lat            <= ~lat;
        reset          <= 1'b1;
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, `CWSL_REG_SEC, rd);
        check(rd, {8'h00, `CWSL_ERASED});
        n = 0;
        while (cfg_loaded !== 1'b1 && n < 300)
        begin
            n++;
            @(negedge sys_clk);
        end
        @(posedge sys_clk);
        check({31'h0, cfg_loaded}, 32'h1);
        base = (size == CWSL_MEM_32K) ? `CWSL_BASE_32K :
               (size == CWSL_MEM_64K) ? `CWSL_BASE_64K : `CWSL_BASE_16K;
        p    = dual ? pick(wword(base + 24'h00007C), wword(base + 24'h40007C)) : 1'b0;
        pofs = p ? 24'h400000 : 24'h000000;
        check({31'h0, active_panel}, {31'h0, p});
        for (int i = 0; i < 8; i++)
        begin
            e = erased ? `CWSL_ERASED : wword(base + pofs + word_ofs[i]);
            bus(1'b1, reg_adr[i], rd);
            bus(1'b0, reg_adr[i], rd);
            check(rd, {8'h00, e});
        end
        bus(1'b0, `CWSL_REG_BOOT, rd);
        check(rd, {8'h00, dual ? wword(base + pofs + 24'h00007C) : `CWSL_ERASED});
        bus(1'b0, `CWSL_REG_STATUS, rd);
        check(rd, {29'h0, dual, p, 1'b1});
    endtask

    initial
    begin
        fill(`CWSL_BASE_16K);
        fill(`CWSL_BASE_32K);
        fill(`CWSL_BASE_64K);
        load_check(CWSL_MEM_16K, 1'b0, 1'b0);
        load_check(CWSL_MEM_RSVD, 1'b0, 1'b0);
        load_check(CWSL_MEM_32K, 1'b0, 1'b0);
        pulse_in(`CWSL_BASE_32K + 24'h00007F, 1'b0, 1'b1);
        pulse_in(`CWSL_BASE_32K + 24'h000080, 1'b0, 1'b0);
        pulse_in(`CWSL_BASE_32K - 24'h000001, 1'b0, 1'b0);
        bus(1'b0, `CWSL_REG_STATUS, rd);
        check(rd & 32'h10, 32'h10);
        // The bench stands in for the reset controller answering the fetch reset request.
        load_check(CWSL_MEM_32K, 1'b0, 1'b0);
        for (int c = 0; c < 5; c++)
        begin
            i_cwsl_flash_model.mem[`CWSL_BASE_64K + 24'h00007C] = seq1[c];
            i_cwsl_flash_model.mem[`CWSL_BASE_64K + 24'h40007C] = seq2[c];
            load_check(CWSL_MEM_64K, 1'b1, 1'b0);
        end
        pulse_in(24'h000000, 1'b1, 1'b1);
        bus(1'b0, `CWSL_REG_SEC, rd);
        check(rd, {8'h00, wword(`CWSL_BASE_64K)});
        // The part is still strapped as 64 Kbyte, so its own last page is the one erased.
        erase_addr   <= `CWSL_BASE_64K;
        erase_strobe <= 1'b1;
        @(posedge sys_clk);
        erase_strobe <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, `CWSL_REG_STATUS, rd);
        check(rd & 32'h8, 32'h8);
        load_check(CWSL_MEM_64K, 1'b0, 1'b1);
        bus(1'b0, 16'h2B84, rd);
        check(rd, 32'h0);
        finish_test();
    end

    initial
    begin
        #1000000;
        bad_count++;
        finish_test();
    end
endmodule
